/* File: rtl/rsc_pkg.sv */
package rsc_pkg;

  // Register byte offsets
  localparam logic [3:0] RSC_CAUSE_OFS = 4'h0;
  localparam logic [3:0] RSC_CTRL_OFS = 4'h4;
  localparam logic [3:0] RSC_INPUT_DISABLE_REG_0_OFS = 4'h8;
  localparam logic [3:0] RSC_INPUT_DISABLE_REG_1_OFS = 4'hC;
  localparam logic [4:0] RSC_INPUT_DISABLE_REG_2_OFS = 5'h10;
  localparam logic [4:0] RSC_STAT_OFS = 5'h14;

  // Cause register bit positions
  localparam int RSC_POR_BIT = 0;
  localparam int RSC_EXT_BIT = 1;
  localparam int RSC_BOR_BIT = 2;
  localparam int RSC_WDR_BIT = 3;
  localparam int RSC_JTR_BIT = 4;
  // Control register bit positions
  localparam int RSC_JTD_BIT = 0;
  localparam int RSC_ACBG_BIT = 1;
  localparam int RSC_ADCEN_BIT = 2;

  // Brown-out level fuse codes
  localparam logic [2:0] RSC_BOD_OFF = 3'h7;
  localparam logic [2:0] RSC_BOD_1V8 = 3'h6;
  localparam logic [2:0] RSC_BOD_2V7 = 3'h5;
  localparam logic [2:0] RSC_BOD_4V3 = 3'h4;

  // Stretch time-out choices, in microseconds, picked by the fuses
  localparam int RSC_CLK_MHZ = 40;
  localparam int RSC_TOUT_SHORT_US = 4;
  localparam int RSC_TOUT_MID_US = 16;
  localparam int RSC_TOUT_LONG_US = 65;
  localparam logic [11:0] RSC_TOUT_SHORT_CYC = 12'(RSC_TOUT_SHORT_US * RSC_CLK_MHZ);
  localparam logic [11:0] RSC_TOUT_MID_CYC = 12'(RSC_TOUT_MID_US * RSC_CLK_MHZ);
  localparam logic [11:0] RSC_TOUT_LONG_CYC = 12'(RSC_TOUT_LONG_US * RSC_CLK_MHZ);
  localparam logic [11:0] RSC_TOUT_NONE_CYC = 12'h001;

  localparam logic [31:0] RSC_BAD_ADDR_DATA = 32'h0000_0000;

  typedef enum logic [2:0]
  {
    RSC_HOLD = 3'b001,
    RSC_STRETCH = 3'b010,
    RSC_RUN = 3'b100
  } rsc_state_t;

  // Reset source levels, one per source
  typedef struct packed
  {
    logic jtag;
    logic wdog;
    logic supply_drop_detector;
    logic ext;
    logic por;
  } rsc_src_t;

  // Whole module state except the reset-release flops and port_rst_q
  typedef struct packed
  {
    rsc_state_t st;
    logic [11:0] cnt;
    rsc_src_t sync1;
    rsc_src_t sync2;
    logic [4:0] cause;
    logic jtag_disable_bit;
    logic acbg;
    logic adc_en;
    logic [7:0] input_disable_reg_0;
    logic [7:0] input_disable_reg_1;
    logic [7:0] input_disable_reg_2;
    logic ack;
    logic [31:0] dat;
    logic sys_rst;
    logic bod_on;
    logic wdt_on;
    logic vref_on;
    logic ocd_on;
    logic clk_keep;
    logic buf_off;
    logic [23:0] pin_buf_off;
  } rsc_regs_t;

endpackage : rsc_pkg

/* File: rtl/rsc_top.sv */
`timescale 1ns/10ps
`default_nettype none

module rsc_top (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic supply_below_por,
  input wire logic ext_reset_n,
  input wire logic wdog_expire,
  input wire logic wdog_enable,
  input wire logic supply_below_bot,
  input wire logic jtag_reset_reg,
  input wire logic [2:0] brownout_level_fuses,
  input wire logic [1:0] startup_time_fuses,
  input wire logic [3:0] clock_select_fuses,
  input wire logic debug_enable_fuse,
  input wire logic jtag_enable_fuse,
  input wire logic sleep_active,
  input wire logic io_clk_stopped,
  input wire logic adc_clk_stopped,
  input wire logic acomp_needs_ref,
  input wire logic [23:0] wake_pin_mask,
  output logic port_reset,
  output logic sys_reset,
  output logic bod_enable,
  output logic wdt_enable,
  output logic vref_enable,
  output logic debug_enable,
  output logic main_clk_keep,
  output logic input_buf_disable,
  output logic [23:0] pin_buf_disable
);
  import rsc_pkg::*;

  rsc_regs_t r;
  rsc_regs_t next_r;
  logic rst_s1;
  logic rst_s2;
  logic rst_n;
  logic async_src;
  logic port_rst_q;
  rsc_src_t raw;
  logic bod_fuse_on;
  logic [11:0] tout;
  logic src_any;
  logic wb_req;
  logic [31:0] stat_word;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  assign rst_n = rst_s2;

  // Source levels; watchdog and brown-out gated by their enables
  assign bod_fuse_on = (brownout_level_fuses == RSC_BOD_1V8) ||
                       (brownout_level_fuses == RSC_BOD_2V7) ||
                       (brownout_level_fuses == RSC_BOD_4V3);
  assign raw.por = supply_below_por;
  assign raw.ext = ~ext_reset_n;
  assign raw.wdog = wdog_expire & wdog_enable;
  assign raw.supply_drop_detector = supply_below_bot & bod_fuse_on;
  assign raw.jtag = jtag_reset_reg;

  // Any level source, clockless path to the ports; watchdog pulse is synchronous
  assign async_src = raw.por | raw.ext | raw.supply_drop_detector | raw.jtag | ~resetn;

  // Port reset set asynchronously, then follows the internal reset on the clock until the stretch ends
  always_ff @(posedge mclk or posedge async_src)
  begin
    if (async_src)
      port_rst_q <= 1'b1;
    else if (clk_en)
      port_rst_q <= r.sys_rst;
  end
  assign port_reset = port_rst_q;

  // Stretch length from start-up and clock-select fuses
  always_comb
  begin
    case (startup_time_fuses)
      2'h0: tout = RSC_TOUT_NONE_CYC;
      2'h1: tout = RSC_TOUT_SHORT_CYC;
      2'h2: tout = RSC_TOUT_MID_CYC;
      default: tout = RSC_TOUT_LONG_CYC;
    endcase
    // Crystal selections need the longest settle, unless the start-up code is zero
    if (clock_select_fuses[3] && startup_time_fuses != 2'h0)
      tout = RSC_TOUT_LONG_CYC;
  end

  assign src_any = |r.sync2;
  assign wb_req = wb_cyc_i & wb_stb_i & ~r.ack;
  assign stat_word = {29'h0000000, r.st};

  // Next-state logic
  always_comb
  begin
    next_r = r;
    next_r.ack = 1'b0;
    // Two-flop synchroniser; first stage read only by the second
    next_r.sync1 = raw;
    next_r.sync2 = r.sync1;

    // Reset sequencer
    case (r.st)
      RSC_HOLD:
      begin
        next_r.sys_rst = 1'b1;
        if (!src_any)
        begin
          next_r.st = RSC_STRETCH;
          next_r.cnt = tout;
        end
      end
      RSC_STRETCH:
      begin
        if (src_any)
          next_r.st = RSC_HOLD;
        else if (r.cnt <= 12'h001)
        begin
          next_r.st = RSC_RUN;
          next_r.sys_rst = 1'b0;
        end
        else
          next_r.cnt = r.cnt - 12'h001;
      end
      RSC_RUN:
      begin
        if (src_any)
        begin
          next_r.st = RSC_HOLD;
          next_r.sys_rst = 1'b1;
        end
      end
      default:
        next_r.st = RSC_HOLD;
    endcase

    // Register writes first so a same-cycle source event wins
    if (wb_req && wb_we_i && wb_sel_i[0])
    begin
      if (wb_adr_i == 5'(RSC_CAUSE_OFS))
        next_r.cause = r.cause & wb_dat_i[4:0];
      else if (wb_adr_i == 5'(RSC_CTRL_OFS))
      begin
        next_r.jtag_disable_bit = wb_dat_i[RSC_JTD_BIT];
        next_r.acbg = wb_dat_i[RSC_ACBG_BIT];
        next_r.adc_en = wb_dat_i[RSC_ADCEN_BIT];
      end
      else if (wb_adr_i == 5'(RSC_INPUT_DISABLE_REG_0_OFS))
        next_r.input_disable_reg_0 = wb_dat_i[7:0];
      else if (wb_adr_i == 5'(RSC_INPUT_DISABLE_REG_1_OFS))
        next_r.input_disable_reg_1 = wb_dat_i[7:0];
      else if (wb_adr_i == RSC_INPUT_DISABLE_REG_2_OFS)
        next_r.input_disable_reg_2 = wb_dat_i[7:0];
    end

    // Cause flags; power-on clears the others but not itself
    if (r.sync2.por)
      next_r.cause = 5'h01;
    else
    begin
      if (r.sync2.ext)
        next_r.cause[RSC_EXT_BIT] = 1'b1;
      if (r.sync2.supply_drop_detector)
        next_r.cause[RSC_BOR_BIT] = 1'b1;
      if (r.sync2.wdog)
        next_r.cause[RSC_WDR_BIT] = 1'b1;
      if (r.sync2.jtag)
        next_r.cause[RSC_JTR_BIT] = 1'b1;
    end

    // Internal reset returns control bits to initial values
    if (r.sys_rst)
    begin
      next_r.jtag_disable_bit = 1'b0;
      next_r.acbg = 1'b0;
      next_r.adc_en = 1'b0;
      next_r.input_disable_reg_0 = 8'h00;
      next_r.input_disable_reg_1 = 8'h00;
      next_r.input_disable_reg_2 = 8'h00;
    end

    // Bus answer one cycle after the request
    if (wb_req)
    begin
      next_r.ack = 1'b1;
      if (wb_we_i)
        next_r.dat = r.dat;
      else if (wb_adr_i == 5'(RSC_CAUSE_OFS))
        next_r.dat = {27'h0000000, r.cause};
      else if (wb_adr_i == 5'(RSC_CTRL_OFS))
        next_r.dat = {29'h00000000, r.adc_en, r.acbg, r.jtag_disable_bit};
      else if (wb_adr_i == 5'(RSC_INPUT_DISABLE_REG_0_OFS))
        next_r.dat = {24'h000000, r.input_disable_reg_0};
      else if (wb_adr_i == 5'(RSC_INPUT_DISABLE_REG_1_OFS))
        next_r.dat = {24'h000000, r.input_disable_reg_1};
      else if (wb_adr_i == RSC_INPUT_DISABLE_REG_2_OFS)
        next_r.dat = {24'h000000, r.input_disable_reg_2};
      else if (wb_adr_i == RSC_STAT_OFS)
        next_r.dat = stat_word;
      else
        next_r.dat = RSC_BAD_ADDR_DATA;
    end

    // Power-management enables, independent of sleep for detector and watchdog
    next_r.bod_on = bod_fuse_on;
    next_r.wdt_on = wdog_enable;
    next_r.vref_on = bod_fuse_on | r.acbg | acomp_needs_ref | r.adc_en;
    next_r.ocd_on = debug_enable_fuse & jtag_enable_fuse & ~r.jtag_disable_bit;
    next_r.clk_keep = sleep_active & r.ocd_on;
    next_r.buf_off = sleep_active & io_clk_stopped & adc_clk_stopped;
    next_r.pin_buf_off = {r.input_disable_reg_2, r.input_disable_reg_1, r.input_disable_reg_0} |
                         ({24{r.buf_off}} & ~wake_pin_mask);
  end

  // State register, frozen by the clock enable
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.st <= RSC_HOLD;
      r.sys_rst <= 1'b1;
      r.cause <= 5'h01;
    end
    else if (clk_en)
      r <= next_r;
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.dat;
  assign sys_reset = r.sys_rst;
  assign bod_enable = r.bod_on;
  assign wdt_enable = r.wdt_on;
  assign vref_enable = r.vref_on;
  assign debug_enable = r.ocd_on;
  assign main_clk_keep = r.clk_keep;
  assign input_buf_disable = r.buf_off;
  assign pin_buf_disable = r.pin_buf_off;

endmodule : rsc_top

`default_nettype wire

/* File: testbench/rsc_top_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module rsc_top_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ext_reset_n,
  input wire logic supply_below_por,
  input wire logic [1:0] startup_time_fuses,
  input wire logic [3:0] clock_select_fuses,
  input wire logic [2:0] brownout_level_fuses,
  input wire logic wdog_enable,
  input wire logic debug_enable_fuse,
  input wire logic jtag_enable_fuse,
  input wire logic sleep_active,
  input wire logic io_clk_stopped,
  input wire logic adc_clk_stopped,
  input wire logic port_reset,
  input wire logic sys_reset,
  input wire logic bod_enable,
  input wire logic wdt_enable,
  input wire logic vref_enable,
  input wire logic debug_enable,
  input wire logic main_clk_keep,
  input wire logic input_buf_disable
);
  // One clock domain, so one default for all checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Pin release at the 160-cycle stretch setting
  sequence s_pin_up;
    $rose(ext_reset_n) && !supply_below_por && startup_time_fuses == 2'h1 && !clock_select_fuses[3];
  endsequence
  sequence s_hold_free;
    ##150 sys_reset ##[1:25] !sys_reset;
  endsequence
  property p_stretch; s_pin_up |-> s_hold_free; endproperty
  a_stretch: assert property (p_stretch) else $error("stretch length wrong");
  property p_pin_async; !ext_reset_n |-> port_reset; endproperty
  a_pin_async: assert property (p_pin_async) else $error("port reset late");
  property p_pin_reach; (!ext_reset_n)[*5] |-> sys_reset; endproperty
  a_pin_reach: assert property (p_pin_reach) else $error("pin ignored");
  property p_por_fast; $rose(supply_below_por) |-> ##[1:4] sys_reset; endproperty
  a_por_fast: assert property (p_por_fast) else $error("power-on slow");
  property p_bod_on; (brownout_level_fuses inside {3'h4, 3'h5, 3'h6})[*5] |-> bod_enable; endproperty
  a_bod_on: assert property (p_bod_on) else $error("detector off");
  property p_bod_off; (!brownout_level_fuses[2] || brownout_level_fuses == 3'h7)[*5] |-> !bod_enable;
  endproperty
  a_bod_off: assert property (p_bod_off) else $error("detector on");
  property p_wdt; wdog_enable[*5] |-> wdt_enable; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog off");
  property p_dbg; (!debug_enable_fuse || !jtag_enable_fuse)[*5] |-> !debug_enable; endproperty
  a_dbg: assert property (p_dbg) else $error("debug on");
  property p_keep; (debug_enable && sleep_active)[*5] |-> main_clk_keep; endproperty
  a_keep: assert property (p_keep) else $error("clock dropped");
  property p_vref; bod_enable[*5] |-> vref_enable; endproperty
  a_vref: assert property (p_vref) else $error("reference off");
  property p_buf; (sleep_active && io_clk_stopped && adc_clk_stopped)[*5] |-> input_buf_disable;
  endproperty
  a_buf: assert property (p_buf) else $error("buffers on");
endmodule : rsc_top_checker
bind rsc_top rsc_top_checker chk_u (.mclk(mclk), .resetn(resetn), .ext_reset_n(ext_reset_n),
  .supply_below_por(supply_below_por), .startup_time_fuses(startup_time_fuses),
  .clock_select_fuses(clock_select_fuses), .brownout_level_fuses(brownout_level_fuses),
  .wdog_enable(wdog_enable), .debug_enable_fuse(debug_enable_fuse),
  .jtag_enable_fuse(jtag_enable_fuse), .sleep_active(sleep_active),
  .io_clk_stopped(io_clk_stopped), .adc_clk_stopped(adc_clk_stopped), .port_reset(port_reset),
  .sys_reset(sys_reset), .bod_enable(bod_enable), .wdt_enable(wdt_enable),
  .vref_enable(vref_enable), .debug_enable(debug_enable), .main_clk_keep(main_clk_keep),
  .input_buf_disable(input_buf_disable));
`default_nettype wire

/* File: testbench/rsc_src_model.sv */
`timescale 1ns/10ps
`default_nettype none
module rsc_src_model (
  input wire logic mclk,
  input wire logic [4:0] want,
  output logic supply_below_por,
  output logic ext_reset_n,
  output logic wdog_expire,
  output logic supply_below_bot,
  output logic jtag_reset_reg
);
  logic wd_d;
  // Healthy supply and idle pin from time zero
  initial
  begin
    supply_below_por = 1'b0;
    ext_reset_n = 1'b1;
    wdog_expire = 1'b0;
    supply_below_bot = 1'b0;
    jtag_reset_reg = 1'b0;
    wd_d = 1'b0;
  end
  // Sources change just after an edge
  always @(posedge mclk)
  begin
    supply_below_por <= want[0];
    ext_reset_n <= !want[1]; // Held low well past a glitch
    wd_d <= want[2];
    wdog_expire <= want[2] && !wd_d; // Single-cycle expiry
    supply_below_bot <= want[3];
    jtag_reset_reg <= want[4];
  end
endmodule : rsc_src_model
`default_nettype wire

/* File: testbench/rsc_top_test.sv */
`timescale 1ns/10ps
`default_nettype none
module rsc_top_test;
  logic mclk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, wden = 1, dbgf = 1, jtgf = 1;
  logic slp = 0, iostp = 0, adcstp = 0;
  logic [4:0] adr = 5'h00, want = 5'h00;
  logic [31:0] wdat = 32'h0, q;
  logic [2:0] bodf = 3'h7;
  logic [23:0] wake = 24'h000003;
  wire [31:0] rdat;
  wire [23:0] pbd;
  wire por, extn, wdx, bot, jtr, ack, prst, srst, bode, wdte, vre, dbge, keep, ibd;
  int err_total = 0, n_checks = 0;
  initial
    forever #12.5 mclk = ~mclk;
  rsc_src_model src_u (.mclk(mclk), .want(want), .supply_below_por(por), .ext_reset_n(extn),
    .wdog_expire(wdx), .supply_below_bot(bot), .jtag_reset_reg(jtr));
  rsc_top dut_u (.mclk(mclk), .resetn(resetn), .clk_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .supply_below_por(por), .ext_reset_n(extn), .wdog_expire(wdx),
    .wdog_enable(wden), .supply_below_bot(bot), .jtag_reset_reg(jtr),
    .brownout_level_fuses(bodf), .startup_time_fuses(2'h1), .clock_select_fuses(4'h0),
    .debug_enable_fuse(dbgf), .jtag_enable_fuse(jtgf), .sleep_active(slp),
    .io_clk_stopped(iostp), .adc_clk_stopped(adcstp), .acomp_needs_ref(1'b0),
    .wake_pin_mask(wake), .port_reset(prst), .sys_reset(srst), .bod_enable(bode),
    .wdt_enable(wdte), .vref_enable(vre), .debug_enable(dbge), .main_clk_keep(keep),
    .input_buf_disable(ibd), .pin_buf_disable(pbd));
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  task automatic cyc_n(input int k);
    repeat (k) @(posedge mclk);
  endtask : cyc_n
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk_word
  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask : chk_bit
  // Hold the request until ack is seen at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 50)
    begin
      err_total++;
      summarize();
    end
    @(posedge mclk);
  endtask : bus
  task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk_word(nm, e, q);
  endtask : rd
  // Bounded wait for the stretch to end
  task automatic wait_rst;
    int n;
    n = 0;
    while (srst !== 1'b0 && n < 4000)
    begin
      @(posedge mclk);
      n++;
    end
    if (n == 4000)
    begin
      err_total++;
      summarize();
    end
  endtask : wait_rst
  // One source asserted, released, then its cause flag read and cleared
  task automatic src_case(input int i, input int len, input logic [4:0] c);
    want <= want | 5'(1 << i);
    cyc_n(len);
    if (i != 2) chk_bit("port_reset", 1'b1, prst);
    want <= want & ~5'(1 << i);
    cyc_n(6);
    chk_bit("sys_reset", 1'b1, srst);
    wait_rst();
    rd("cause", 5'h00, {27'h0, c});
    bus(1'b1, 5'h00, 32'h0);
  endtask : src_case
  // Main sequence
  initial
  begin
    cyc_n(5);
    resetn <= 1'b1;
    cyc_n(3);
    wait_rst();
    rd("cause", 5'h00, 32'h1);
    rd("status", 5'h14, 32'h4);
    bus(1'b1, 5'h00, 32'h0);
    rd("cause", 5'h00, 32'h0);
    bus(1'b1, 5'h08, 32'hA5);
    cyc_n(2);
    chk_word("pin_buf", 32'hA5, {8'h0, pbd});
    rd("unmapped", 5'h18, 32'h0);
    wden <= 1'b0;
    want[2] <= 1'b1;
    cyc_n(1);
    want[2] <= 1'b0;
    cyc_n(8);
    chk_bit("sys_reset", 1'b0, srst);
    wden <= 1'b1;
    src_case(1, 12, 5'h02);
    src_case(2, 1, 5'h08);
    src_case(4, 12, 5'h10);
    for (int c = 0; c < 8; c++)
    begin
      bodf <= 3'(c);
      cyc_n(6);
      chk_bit("bod_en", c inside {4, 5, 6}, bode);
    end
    want[3] <= 1'b1;
    cyc_n(8);
    chk_bit("sys_reset", 1'b0, srst);
    bodf <= 3'h6;
    src_case(3, 12, 5'h04);
    bodf <= 3'h7;
    bus(1'b1, 5'h04, 32'h1);
    cyc_n(3);
    chk_bit("debug", 1'b0, dbge);
    bus(1'b1, 5'h04, 32'h2);
    slp <= 1'b1;
    iostp <= 1'b1;
    adcstp <= 1'b1;
    cyc_n(6);
    chk_bit("clk_keep", 1'b1, keep);
    chk_bit("vref", 1'b1, vre);
    chk_bit("in_buf", 1'b1, ibd);
    chk_bit("wdt", 1'b1, wdte);
    chk_bit("debug", 1'b1, dbge);
    chk_word("pin_buf", 32'h00FFFFFC, {8'h0, pbd});
    jtgf <= 1'b0;
    cyc_n(6);
    chk_bit("debug", 1'b0, dbge);
    src_case(0, 12, 5'h01);
    summarize();
  end
endmodule : rsc_top_test
`default_nettype wire
